// ==== common/cis_pkg.sv ====
package cis_pkg;

  // Widths of the register port and of the program counter
  localparam int CIS_AW  = 8;
  localparam int CIS_DW  = 8;
  localparam int CIS_PCW = 15;

  // Register offsets on the plain register port
  localparam logic [7:0] CIS_ADDR_CTRL      = 8'h00;
  localparam logic [7:0] CIS_ADDR_CORE_EN   = 8'h01;
  localparam logic [7:0] CIS_ADDR_CORE_FLAG = 8'h02;
  localparam logic [7:0] CIS_ADDR_PEND_BASE = 8'h03;  // pending_flags_one..four at 03h..06h
  localparam logic [7:0] CIS_ADDR_PSE_BASE  = 8'h07;  // per_source_enable one..four at 07h..0Ah
  localparam logic [7:0] CIS_ADDR_EVT_STAT  = 8'h0B;
  localparam logic [7:0] CIS_ADDR_EVT_MASK  = 8'h0C;

  // Field positions
  localparam int CIS_GIE_BIT  = 7;  // irq_control_reg: global_irq_enable
  localparam int CIS_PERIPHERAL_GROUP_ENABLE_BIT = 6;  // irq_control_reg: peripheral_group_enable
  localparam int CIS_EDGE_BIT = 0;  // irq_control_reg: ext_edge_select
  localparam int CIS_EXT_BIT  = 0;  // core regs: ext_pin_irq_enable / ext_pin_irq_flag
  localparam int CIS_TO_BIT   = 4;  // status: timeout_bit
  localparam int CIS_PD_BIT   = 3;  // status: powerdown_bit

  // Block event bits in the event status and mask registers
  localparam int CIS_EV_ENTRY  = 0;
  localparam int CIS_EV_RETURN = 1;
  localparam int CIS_EV_WAKE   = 2;

  // Reset values
  localparam logic [7:0] CIS_CTRL_RST = 8'h00;
  localparam logic [7:0] CIS_EN_RST   = 8'h00;
  localparam logic [7:0] CIS_FLAG_RST = 8'h00;
  localparam logic [7:0] CIS_EVT_RST  = 8'h00;

  // Fixed handler entry address
  localparam logic [CIS_PCW-1:0] CIS_VECTOR = 15'h0004;

  // One register port access
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [CIS_AW-1:0] addr;
    logic [CIS_DW-1:0] wdata;
  } cis_bus_t;

  // Core context shadowed on entry and restored on return
  typedef struct packed {
    logic [7:0]  w;
    logic [7:0]  status;
    logic [5:0]  bank_select;
    logic [15:0] indirect_pointer0;
    logic [15:0] indirect_pointer1;
    logic [6:0]  pc_high_latch;
  } cis_ctx_t;

  // Command to the program sequencer, one-cycle pulses
  typedef struct packed {
    logic               flush;
    logic               push;
    logic               load_pc;
    logic               pop;
    logic               restore;
    logic [CIS_PCW-1:0] push_addr;
    logic [CIS_PCW-1:0] target_pc;
  } cis_seq_t;

  typedef enum logic [1:0] {CIS_ST_RUN, CIS_ST_SLEEP, CIS_ST_WAKE} cis_state_t;

endpackage

// ==== src/cis_core_interrupt_sequencer.sv ====
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ns
module cis_core_interrupt_sequencer
  import cis_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  input  wire cis_bus_t           bus,
  output logic [CIS_DW-1:0]       rdata,
  output logic                    irq,
  input  wire logic               ext_pin,
  input  wire logic [6:0]         core_evt,
  input  wire logic [31:0]        periph_evt,
  input  wire logic               first_quarter_phase,
  input  wire logic               insn_last,
  input  wire logic [CIS_PCW-1:0] cur_pc,
  input  wire cis_ctx_t           ctx_in,
  input  wire logic               sleeping,
  input  wire logic               return_from_handler,
  output cis_seq_t                seq_cmd,
  output cis_ctx_t                shadow_ctx,
  output logic                    wake
);

  logic [7:0]      irq_control_reg;
  logic [7:0]      core_enable_reg;
  logic [7:0]      core_flag_reg;
  logic [3:0][7:0] pending_flags;
  logic [3:0][7:0] per_source_enable;
  logic [7:0]      evt_status;
  logic [7:0]      evt_mask;
  logic            ext_s1;
  logic            ext_s2;
  logic            ext_s3;
  logic            edge_hit;
  logic            global_irq_enable;
  logic            peripheral_group_enable;
  logic            ext_edge_select;
  logic            core_req;
  logic            per_req;
  logic            any_req;
  logic            accept;
  logic            do_return;
  logic            wake_now;
  logic [7:0]      new_events;
  cis_state_t      state;

  assign global_irq_enable       = irq_control_reg[CIS_GIE_BIT];
  assign peripheral_group_enable = irq_control_reg[CIS_PERIPHERAL_GROUP_ENABLE_BIT];
  assign ext_edge_select         = irq_control_reg[CIS_EDGE_BIT];

  // Pin synchroniser; the third stage only serves the edge detector
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end
    else
    begin
      ext_s1 <= ext_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  // Edge select picks the active pin edge
  assign edge_hit = ext_edge_select ? (ext_s2 & ~ext_s3) : (~ext_s2 & ext_s3);

  // Request terms; core sources skip the group enable
  assign core_req = |(core_flag_reg & core_enable_reg);
  assign per_req  = peripheral_group_enable & (|(pending_flags & per_source_enable));
  assign any_req  = core_req | per_req;

  // Taken only at an instruction boundary, so latency follows the running instruction
  assign accept    = global_irq_enable & any_req & first_quarter_phase & insn_last
                     & (state == CIS_ST_RUN);
  assign do_return = return_from_handler;
  assign wake_now  = (state == CIS_ST_SLEEP) & any_req;

  // Control register; entry clears the global enable and wins over a write
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      irq_control_reg <= CIS_CTRL_RST;
    end
    else
    begin
      if (bus.wr && bus.addr == CIS_ADDR_CTRL)
      begin
        irq_control_reg <= bus.wdata;
      end
      if (accept)
      begin
        irq_control_reg[CIS_GIE_BIT] <= 1'b0;
      end
      else if (do_return)
      begin
        irq_control_reg[CIS_GIE_BIT] <= 1'b1;
      end
    end
  end

  // Enable registers are plain software storage
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      core_enable_reg   <= CIS_EN_RST;
      per_source_enable <= '0;
    end
    else
    begin
      if (bus.wr && bus.addr == CIS_ADDR_CORE_EN)
      begin
        core_enable_reg <= bus.wdata;
      end
      for (int i = 0; i < 4; i++)
      begin
        if (bus.wr && bus.addr == CIS_ADDR_PSE_BASE + 8'(i))
        begin
          per_source_enable[i] <= bus.wdata;
        end
      end
    end
  end

  // Flags: an event always sets, and a set beats a software clear in the same cycle
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      core_flag_reg <= CIS_FLAG_RST;
      pending_flags <= '0;
    end
    else
    begin
      core_flag_reg <= ((bus.wr && bus.addr == CIS_ADDR_CORE_FLAG) ? bus.wdata : core_flag_reg)
                       | {core_evt, edge_hit};
      for (int i = 0; i < 4; i++)
      begin
        pending_flags[i] <= ((bus.wr && bus.addr == CIS_ADDR_PEND_BASE + 8'(i)) ? bus.wdata : pending_flags[i])
                            | periph_evt[i*8 +: 8];
      end
    end
  end

  // Sleep tracking; after a wake one instruction must retire before any entry
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      state <= CIS_ST_RUN;
    end
    else
    begin
      case (state)
        CIS_ST_RUN:
        begin
          if (sleeping && !accept)
          begin
            state <= CIS_ST_SLEEP;
          end
        end
        CIS_ST_SLEEP:
        begin
          if (wake_now)
          begin
            state <= CIS_ST_WAKE;
          end
        end
        CIS_ST_WAKE:
        begin
          if (first_quarter_phase && insn_last)
          begin
            state <= CIS_ST_RUN;
          end
        end
        default:
        begin
          state <= CIS_ST_RUN;
        end
      endcase
    end
  end

  // Wake strobe to the clock and power logic
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      wake <= 1'b0;
    end
    else
    begin
      wake <= wake_now;
    end
  end

  // Sequencer commands are one-cycle pulses; vector target is constant
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      seq_cmd <= '0;
    end
    else
    begin
      seq_cmd.flush     <= accept;
      seq_cmd.push      <= accept;
      seq_cmd.load_pc   <= accept;
      seq_cmd.pop       <= do_return & ~accept;
      seq_cmd.restore   <= do_return & ~accept;
      seq_cmd.push_addr <= accept ? cur_pc : seq_cmd.push_addr;
      seq_cmd.target_pc <= CIS_VECTOR;
    end
  end

  // Shadow copy; timeout and powerdown stay live so they are not captured
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      shadow_ctx <= '0;
    end
    else if (accept)
    begin
      shadow_ctx                    <= ctx_in;
      shadow_ctx.status[CIS_TO_BIT] <= 1'b0;
      shadow_ctx.status[CIS_PD_BIT] <= 1'b0;
    end
  end

  // Block events for the status register
  always_comb
  begin
    new_events                = 8'h00;
    new_events[CIS_EV_ENTRY]  = accept;
    new_events[CIS_EV_RETURN] = do_return;
    new_events[CIS_EV_WAKE]   = wake_now;
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      evt_status <= CIS_EVT_RST;
      evt_mask   <= CIS_EVT_RST;
    end
    else
    begin
      evt_status <= ((bus.wr && bus.addr == CIS_ADDR_EVT_STAT) ? (evt_status & ~bus.wdata) : evt_status)
                    | new_events;
      if (bus.wr && bus.addr == CIS_ADDR_EVT_MASK)
      begin
        evt_mask <= bus.wdata;
      end
    end
  end

  // Interrupt level trails the status by one cycle to stay a flop output
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(evt_status & evt_mask);
    end
  end

  // Read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      rdata <= 8'h00;
    end
    else if (bus.rd)
    begin
      case (bus.addr)
        CIS_ADDR_CTRL:          rdata <= irq_control_reg;
        CIS_ADDR_CORE_EN:       rdata <= core_enable_reg;
        CIS_ADDR_CORE_FLAG:     rdata <= core_flag_reg;
        CIS_ADDR_PEND_BASE:     rdata <= pending_flags[0];
        CIS_ADDR_PEND_BASE + 8'h01: rdata <= pending_flags[1];
        CIS_ADDR_PEND_BASE + 8'h02: rdata <= pending_flags[2];
        CIS_ADDR_PEND_BASE + 8'h03: rdata <= pending_flags[3];
        CIS_ADDR_PSE_BASE:          rdata <= per_source_enable[0];
        CIS_ADDR_PSE_BASE + 8'h01:  rdata <= per_source_enable[1];
        CIS_ADDR_PSE_BASE + 8'h02:  rdata <= per_source_enable[2];
        CIS_ADDR_PSE_BASE + 8'h03:  rdata <= per_source_enable[3];
        CIS_ADDR_EVT_STAT:      rdata <= evt_status;
        CIS_ADDR_EVT_MASK:      rdata <= evt_mask;
        default:                rdata <= 8'h00;
      endcase
    end
    else
    begin
      rdata <= 8'h00;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_reset_gie_off: assert property ($rose(resetn) |-> !global_irq_enable)
    else $error("global enable set right after reset");
  a_entry_needs_enables: assert property (accept |-> global_irq_enable && (core_req || per_req))
    else $error("entry without enabled request");
  a_peri_group_gate: assert property (!peripheral_group_enable && !core_req |-> !accept)
    else $error("peripheral request taken with group enable clear");
  a_flag_set_always: assert property (periph_evt[0] |=> pending_flags[0][0])
    else $error("peripheral event did not set its flag");
  a_core_flag_set: assert property (core_evt[0] |=> core_flag_reg[1])
    else $error("core event did not set its flag");
  a_entry_sequence: assert property (accept |=> seq_cmd.flush && seq_cmd.push && seq_cmd.load_pc
                                     && seq_cmd.target_pc == CIS_VECTOR && !global_irq_enable
                                     && seq_cmd.push_addr == $past(cur_pc))
    else $error("entry sequence incomplete");
  a_handler_no_redir: assert property (!global_irq_enable |-> !accept)
    else $error("redirect while global enable clear");
  a_return_restores: assert property (do_return && !accept |=> seq_cmd.pop && seq_cmd.restore
                                      && global_irq_enable)
    else $error("return did not pop, restore and enable");
  a_request_held: assert property (any_req && !global_irq_enable && !bus.wr |=> any_req)
    else $error("pending request lost while disabled");
  a_served_when_enabled: assert property (any_req && global_irq_enable && first_quarter_phase && insn_last
                                          && state == CIS_ST_RUN |-> accept)
    else $error("enabled request not served");
  a_q1_sampling: assert property (accept |-> first_quarter_phase && insn_last)
    else $error("request taken outside first quarter phase");
  a_ext_rise_edge: assert property (ext_edge_select && ext_s2 && !ext_s3 |=> core_flag_reg[CIS_EXT_BIT])
    else $error("rising pin edge missed");
  a_ext_no_wrong: assert property (ext_edge_select && !ext_s2 && ext_s3 && !core_flag_reg[CIS_EXT_BIT]
                                   && !bus.wr |=> !core_flag_reg[CIS_EXT_BIT])
    else $error("falling edge set flag in rising mode");
  a_shadow_masked: assert property (accept |=> shadow_ctx.w == $past(ctx_in.w)
                                    && !shadow_ctx.status[CIS_TO_BIT] && !shadow_ctx.status[CIS_PD_BIT])
    else $error("shadow copy wrong");
  a_wake_no_entry: assert property (wake_now |=> state == CIS_ST_WAKE ##0 !accept)
    else $error("entry before post-sleep instruction");
  a_irq_level: assert property (|(evt_status & evt_mask) |=> irq)
    else $error("interrupt output low with unmasked status");

endmodule

// ==== bench/cis_seq_model.sv ====
`timescale 1ns/1ns
module cis_seq_model
  import cis_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          resetn,
  input  wire cis_seq_t      seq_cmd,
  input  wire cis_ctx_t      shadow_ctx,
  input  wire logic          ret_req,
  output logic               first_quarter_phase,
  output logic               insn_last,
  output logic [CIS_PCW-1:0] cur_pc,
  output cis_ctx_t           ctx_in,
  output logic               return_from_handler
);
  logic [1:0] phase;
  logic       ret_due;

  // Four quarters per instruction; sampling point sits on the boundary
  assign first_quarter_phase = (phase == 2'h0);
  assign insn_last           = (phase == 2'h0);

  // Quarter counter and program counter, jumps follow the block's commands
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      phase  <= 2'h0;
      cur_pc <= 15'h0100;
    end
    else
    begin
      phase <= phase + 2'h1;
      if (seq_cmd.load_pc)
        cur_pc <= seq_cmd.target_pc;
      else if (seq_cmd.pop)
        cur_pc <= seq_cmd.push_addr;
      else if (insn_last)
        cur_pc <= cur_pc + 15'h0001;
    end
  end

  // Handler scribbles on the context so a missed restore shows up
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      ctx_in <= {8'h5A, 8'h1B, 6'h2C, 16'h1234, 16'hBEEF, 7'h55};
    else if (seq_cmd.load_pc)
      ctx_in <= ~ctx_in;
    else if (seq_cmd.restore)
      ctx_in <= shadow_ctx;
  end

  // Return instruction runs at the next boundary after firmware asks
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      ret_due             <= 1'b0;
      return_from_handler <= 1'b0;
    end
    else
    begin
      return_from_handler <= ret_due && insn_last;
      if (ret_req)
        ret_due <= 1'b1;
      else if (insn_last)
        ret_due <= 1'b0;
    end
  end
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/1ns
module tb
  import cis_pkg::*;
;
  logic               ref_clk, resetn, irq, ext_pin, sleeping, wake, ret_req;
  logic               fq_phase, insn_last, ret_pulse;
  logic [6:0]         core_evt;
  logic [31:0]        periph_evt, seed;
  logic [CIS_DW-1:0]  rdata;
  logic [CIS_PCW-1:0] cur_pc, pc_prev;
  cis_bus_t           bus;
  cis_seq_t           seq_cmd;
  cis_ctx_t           ctx_in, shadow_ctx, exp_ctx;
  int                 fails, cmp_count, cycles, flush_cnt, i;
  int                 model [13];

  cis_core_interrupt_sequencer dut_u (.ref_clk(ref_clk), .resetn(resetn), .bus(bus), .rdata(rdata), .irq(irq),
    .ext_pin(ext_pin), .core_evt(core_evt), .periph_evt(periph_evt), .first_quarter_phase(fq_phase),
    .insn_last(insn_last), .cur_pc(cur_pc), .ctx_in(ctx_in), .sleeping(sleeping),
    .return_from_handler(ret_pulse), .seq_cmd(seq_cmd), .shadow_ctx(shadow_ctx), .wake(wake));
  cis_seq_model seq_u (.ref_clk(ref_clk), .resetn(resetn), .seq_cmd(seq_cmd), .shadow_ctx(shadow_ctx),
    .ret_req(ret_req), .first_quarter_phase(fq_phase), .insn_last(insn_last), .cur_pc(cur_pc),
    .ctx_in(ctx_in), .return_from_handler(ret_pulse));

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Entry counter and hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (seq_cmd.flush === 1'b1)
      flush_cnt++;
    if (cycles == 20000)
    begin
      fails++;
      wrap_up();
    end
  end

  // PC as sampled at the previous edge, which is what an entry pushes
  always @(negedge ref_clk)
    pc_prev <= cur_pc;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
      fails++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
    if (a == CIS_ADDR_EVT_STAT)
      model[11] &= ~int'(d);
    else if (a < 8'h0D)
      model[a] = d;
  endtask

  task automatic rd_chk(input logic [7:0] a);
    @(posedge ref_clk);
    bus <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    @(negedge ref_clk);
    chk($sformatf("reg %0h", a), (a < 8'h0D) ? model[a] : 0, rdata);
  endtask

  // One peripheral event pulse, flag register a, bit b
  task automatic ev(input int a, input int b);
    @(posedge ref_clk);
    periph_evt <= 32'h1 << (a * 8 + b);
    @(posedge ref_clk);
    periph_evt <= '0;
    model[3 + a] |= 1 << b;
  endtask

  // Bounded wait for flush (0), pop (1) or wake (2)
  task automatic wait_for(input int sel, input int n, input string what);
    bit hit;
    hit = 1'b0;
    repeat (n)
      if (!hit)
      begin
        @(negedge ref_clk);
        hit = (sel == 0) ? seq_cmd.flush : (sel == 1) ? seq_cmd.pop : wake;
      end
    chk(what, 1, hit);
  endtask

  task automatic entry_chk();
    exp_ctx = ctx_in;
    exp_ctx.status[CIS_TO_BIT] = 1'b0;
    exp_ctx.status[CIS_PD_BIT] = 1'b0;
    chk("push load", 2'b11, {seq_cmd.push, seq_cmd.load_pc});
    chk("target pc", CIS_VECTOR, seq_cmd.target_pc);
    chk("push addr", pc_prev, seq_cmd.push_addr);
    chk("shadow", exp_ctx, shadow_ctx);
    model[0] &= ~32'h80;
    model[11] |= 1;
  endtask

  task automatic ret_and_pop();
    @(posedge ref_clk);
    ret_req <= 1'b1;
    @(posedge ref_clk);
    ret_req <= 1'b0;
    wait_for(1, 12, "pop");
    chk("restore", 1, seq_cmd.restore);
    model[0] |= 32'h80;
    model[11] |= 2;
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    seed = 32'hE3F299EA;
    resetn = 1'b0;
    bus = '0;
    ext_pin = 1'b0;
    sleeping = 1'b0;
    ret_req = 1'b0;
    core_evt = '0;
    periph_evt = '0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    // Reset state of every register and one unmapped place
    for (i = 0; i < 13; i++)
      rd_chk(8'(i));
    rd_chk(8'hF0);
    $display("test reset done");
    // Random events with every enable off still set their flags
    for (i = 0; i < 8; i++)
      ev(xs() % 4, xs() % 8);
    void'(xs());
    @(posedge ref_clk);
    core_evt <= seed[6:0];
    @(posedge ref_clk);
    core_evt <= '0;
    model[2] |= {seed[6:0], 1'b0};
    for (i = 2; i < 7; i++)
      rd_chk(8'(i));
    chk("entries", 0, flush_cnt);
    $display("test flags done");
    // Group enable gates peripheral sources, a held request enters once it is set
    for (i = 2; i < 7; i++)
      wr(8'(i), 8'h00);
    wr(CIS_ADDR_PSE_BASE, 8'h01);
    wr(CIS_ADDR_EVT_MASK, 8'h01);
    wr(CIS_ADDR_CTRL, 8'h80);
    ev(0, 0);
    repeat (12) @(posedge ref_clk);
    chk("entries", 0, flush_cnt);
    wr(CIS_ADDR_CTRL, 8'hC0);
    wait_for(0, 12, "flush");
    entry_chk();
    @(negedge ref_clk);
    chk("irq", 1, irq);
    rd_chk(CIS_ADDR_CTRL);
    rd_chk(CIS_ADDR_PEND_BASE);
    rd_chk(CIS_ADDR_EVT_STAT);
    $display("test entry done");
    // Events inside the handler only set flags
    wr(CIS_ADDR_PSE_BASE + 8'h01, 8'h08);
    ev(1, 3);
    repeat (12) @(posedge ref_clk);
    chk("entries", 1, flush_cnt);
    rd_chk(CIS_ADDR_PEND_BASE + 8'h01);
    wr(CIS_ADDR_EVT_STAT, 8'h01);
    // The interrupt line trails the status register by one cycle
    repeat (2) @(negedge ref_clk);
    chk("irq", 0, irq);
    // Return with flags still set enters again at once
    ret_and_pop();
    wait_for(0, 12, "flush");
    entry_chk();
    wr(CIS_ADDR_PEND_BASE, 8'h00);
    wr(CIS_ADDR_PEND_BASE + 8'h01, 8'h00);
    wr(CIS_ADDR_EVT_STAT, 8'h03);
    ret_and_pop();
    repeat (12) @(posedge ref_clk);
    chk("entries", 2, flush_cnt);
    rd_chk(CIS_ADDR_CTRL);
    rd_chk(CIS_ADDR_EVT_STAT);
    $display("test return done");
    // External pin, both edge selections, wrong edge first
    for (i = 0; i < 2; i++)
    begin
      wr(CIS_ADDR_CTRL, 8'(i));
      ext_pin <= i[0];
      repeat (6) @(posedge ref_clk);
      wr(CIS_ADDR_CORE_FLAG, 8'h00);
      ext_pin <= ~i[0];
      repeat (6) @(posedge ref_clk);
      rd_chk(CIS_ADDR_CORE_FLAG);
      ext_pin <= i[0];
      repeat (6) @(posedge ref_clk);
      model[2] = 1;
      rd_chk(CIS_ADDR_CORE_FLAG);
    end
    $display("test pin done");
    // Wake from sleep with the global enable clear runs on without entry
    wr(CIS_ADDR_CORE_EN, 8'h02);
    sleeping <= 1'b1;
    @(posedge ref_clk);
    core_evt <= 7'h01;
    @(posedge ref_clk);
    core_evt <= '0;
    model[2] |= 2;
    wait_for(2, 8, "wake");
    model[11] |= 4;
    sleeping <= 1'b0;
    repeat (12) @(posedge ref_clk);
    chk("entries", 2, flush_cnt);
    rd_chk(CIS_ADDR_CORE_FLAG);
    rd_chk(CIS_ADDR_EVT_STAT);
    chk("irq masked", 0, irq);
    $display("test sleep done");
    // Reset in mid-run with the global enable set drops every enable and flag again
    wr(CIS_ADDR_CORE_FLAG, 8'h00);
    wr(CIS_ADDR_CTRL, 8'hC0);
    resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    for (i = 0; i < 13; i++)
      model[i] = 0;
    for (i = 0; i < 13; i++)
      rd_chk(8'(i));
    $display("test mid reset done");
    wrap_up();
  end
endmodule
